/* scs_pkg.sv */
// Package for the system clock source switch: register offsets, field layout, reset values, states.
// Assumes an 8-bit register port with one-cycle read latency.
package scs_pkg;
  // Register offsets
  localparam logic [1:0] SCS_OFF_CTRL = 2'h0;
  localparam logic [1:0] SCS_OFF_STAT = 2'h1;
  localparam logic [1:0] SCS_OFF_TIMER1_CONTROL_REG = 2'h2;
  // Control register field positions
  localparam int SCS_SEL_LSB = 0;
  localparam int SCS_FREQ_LSB = 3;
  localparam int SCS_PLL_BIT = 7;
  // Status register field positions
  localparam int SCS_STS_BIT = 0;
  localparam int SCS_SECONDARY_OSC_READY_BIT = 1;
  localparam int SCS_PLL_READY_FLAG_BIT = 2;
  localparam int SCS_BUSY_BIT = 3;
  // Timer1 control: oscillator enable position
  localparam int SCS_SECONDARY_OSC_ENABLE_BIT = 3;
  // Reset values
  localparam logic [1:0] SCS_SEL_RST = 2'h0;
  localparam logic [3:0] SCS_FREQ_RST = 4'h7;
  // Frequency code that feeds the PLL
  localparam logic [3:0] SCS_FREQ_PLL = 4'he;
  // Stabilise wait in cycles for a source that was off
  localparam int SCS_STAB_CYC = 16;
  // Source encoding
  typedef enum logic [1:0] {
    SCS_SRC_CFG = 2'b00,
    SCS_SRC_SEC = 2'b01,
    SCS_SRC_INT = 2'b10
  } scs_src_t;
  // Switch sequence states
  typedef enum logic [2:0] {
    SCS_ST_IDLE = 3'b000,
    SCS_ST_STAB = 3'b001,
    SCS_ST_FALL = 3'b010,
    SCS_ST_RISE = 3'b011,
    SCS_ST_DONE = 3'b100
  } scs_state_t;
  // Map select field to source: upper bit set means internal
  function automatic scs_src_t scs_decode(input logic [1:0] sel);
    scs_decode = sel[1] ? SCS_SRC_INT : (sel[0] ? SCS_SRC_SEC : SCS_SRC_CFG);
  endfunction : scs_decode
endpackage : scs_pkg

/* scs_if.sv */
// Interface carrying the switch request and status between switch core and top.
// Assumes one clock domain.
`timescale 1ns/1ps
interface scs_if;
  logic req; // Request new source
  logic [1:0] src; // Requested source
  logic [1:0] cur; // Active source
  logic busy; // Sequence running
  logic done; // One-cycle completion pulse
  modport ctl (output req, output src, input cur, input busy, input done);
  modport core (input req, input src, output cur, output busy, output done);
endinterface : scs_if

/* scs_seq.sv */
// Glitch-free switch sequence: stabilise, wait falling old, hold low, wait rising new.
// Assumes clock levels of the sources arrive sampled on the system clock.
`timescale 1ns/1ps
module scs_seq
  import scs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  scs_if.core sw,
  input wire logic [2:0] src_lvl,
  input wire logic [2:0] src_on,
  output logic gate_low
);
  scs_state_t state_r;
  logic [1:0] cur_r;
  logic [1:0] tgt_r;
  logic [7:0] cnt_r;
  logic [2:0] lvl_d_r;
  logic old_fall;
  logic new_rise;
  // Edge detectors on sampled source levels
  always_ff @(posedge clock) begin
    if (!rst_n) lvl_d_r <= 3'h0;
    else lvl_d_r <= src_lvl;
  end
  assign old_fall = lvl_d_r[cur_r] && !src_lvl[cur_r];
  assign new_rise = !lvl_d_r[tgt_r] && src_lvl[tgt_r];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SCS_ST_IDLE;
      cur_r <= SCS_SRC_CFG;
      tgt_r <= SCS_SRC_CFG;
      cnt_r <= 8'h00;
    end else begin
      case (state_r)
        SCS_ST_IDLE: begin
          if (sw.req && sw.src != cur_r) begin
            tgt_r <= sw.src;
            cnt_r <= 8'(SCS_STAB_CYC);
            state_r <= src_on[sw.src] ? SCS_ST_FALL : SCS_ST_STAB;
          end
        end
        SCS_ST_STAB: begin
          if (cnt_r > 8'h01) cnt_r <= cnt_r - 8'h01;
          else state_r <= SCS_ST_FALL;
        end
        SCS_ST_FALL: if (old_fall) state_r <= SCS_ST_RISE;
        SCS_ST_RISE: begin
          if (new_rise) begin
            cur_r <= tgt_r;
            state_r <= SCS_ST_DONE;
          end
        end
        SCS_ST_DONE: state_r <= SCS_ST_IDLE;
        default: state_r <= SCS_ST_IDLE;
      endcase
    end
  end
  assign gate_low = (state_r == SCS_ST_RISE);
  assign sw.cur = cur_r;
  assign sw.busy = (state_r != SCS_ST_IDLE);
  assign sw.done = (state_r == SCS_ST_DONE);
  // Checks
  // hold low until rising edge
  chk_gate_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == SCS_ST_RISE && !new_rise) |=> gate_low) else $error("gate released early");
  chk_same_src: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == SCS_ST_IDLE && sw.req && sw.src == cur_r) |=> !sw.busy) else $error("switch on same source");
  cov_switch: cover property (@(posedge clock) disable iff (!rst_n) sw.done);
endmodule : scs_seq

/* scs_top.sv */
// Top of the system clock source switch: register port, status flags and glitch-free source mux.
// Assumes source clock levels and readiness inputs are synchronous to clock; register port has one-cycle reads.
`timescale 1ns/1ps
// How it works
// - Select 00 uses configuration-chosen oscillator
// - Select 01 uses secondary crystal oscillator
// - Upper bit set uses internal oscillator
// - Reset clears the select field
// - Automatic switches leave select field alone
// - Start status shows external source running
// - Start status ignores secondary oscillator
// - Secondary oscillator runs only when enabled
// - Ready flag when secondary oscillator usable
// - New clock stabilises before driving system
// - PLL flag follows completed PLL switches
// - Fall old, hold low, rise new
// - Reset frequency select is 0111
// - Same internal source frequency change instant
// - PLL only with select field 00
module scs_top
  import scs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] config_oscillator_select,
  input wire logic crystal_mode,
  input wire logic start_up_timer_done,
  input wire logic cfg_osc_level,
  input wire logic secondary_osc_level,
  input wire logic secondary_osc_stable,
  input wire logic internal_osc_level,
  input wire logic pll_osc_level,
  input wire logic auto_force_internal,
  output logic secondary_osc_run,
  output logic sys_clk_out,
  output logic [1:0] active_source,
  output logic [3:0] active_freq,
  output logic pll_active
);
  logic [1:0] clock_source_select_r; // Software select field
  logic [3:0] internal_freq_select_r; // Internal frequency select
  logic software_pll_enable_r; // Software PLL enable
  logic secondary_osc_enable_r; // Timer1 oscillator enable
  logic pll_ready_flag_r; // PLL ready status
  logic pll_req; // PLL wanted
  logic [3:0] freq_r; // Active internal frequency
  logic gate_low;
  logic [2:0] src_lvl;
  logic [2:0] src_on;
  logic [1:0] eff_src;
  logic start_timer_status;
  logic secondary_osc_ready;
  logic [7:0] rdata_nxt;
  scs_if sw ();

  // reset clears select field; frequency resets to 0111
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clock_source_select_r <= SCS_SEL_RST;
      internal_freq_select_r <= SCS_FREQ_RST;
      software_pll_enable_r <= 1'b0;
    end else if (reg_wr && reg_addr == SCS_OFF_CTRL) begin
      clock_source_select_r <= reg_wdata[SCS_SEL_LSB +: 2];
      internal_freq_select_r <= reg_wdata[SCS_FREQ_LSB +: 4];
      software_pll_enable_r <= reg_wdata[SCS_PLL_BIT];
    end
  end

  // Timer1 oscillator enable bit
  always_ff @(posedge clock) begin
    if (!rst_n) secondary_osc_enable_r <= 1'b0;
    else if (reg_wr && reg_addr == SCS_OFF_TIMER1_CONTROL_REG) secondary_osc_enable_r <= reg_wdata[SCS_SECONDARY_OSC_ENABLE_BIT];
  end
  // secondary oscillator runs only when enabled
  assign secondary_osc_run = secondary_osc_enable_r;
  assign secondary_osc_ready = secondary_osc_enable_r && secondary_osc_stable;

  // automatic override acts on source only, never on the select field
  assign eff_src = auto_force_internal ? SCS_SRC_INT : scs_decode(clock_source_select_r);
  assign sw.req = 1'b1;
  assign sw.src = eff_src;

  // Source levels and on states, indexed by source code
  assign src_lvl = {internal_osc_level, secondary_osc_level, cfg_osc_level};
  assign src_on = {1'b1, secondary_osc_ready, start_up_timer_done | ~crystal_mode};

  scs_seq u_seq (
    .clock(clock),
    .rst_n(rst_n),
    .sw(sw.core),
    .src_lvl(src_lvl),
    .src_on(src_on),
    .gate_low(gate_low)
  );

  // same-source frequency change applied at once
  always_ff @(posedge clock) begin
    if (!rst_n) freq_r <= SCS_FREQ_RST;
    else freq_r <= internal_freq_select_r;
  end

  // PLL only with PLL enable, select 00, no automatic override and frequency code SCS_FREQ_PLL
  assign pll_req = software_pll_enable_r && clock_source_select_r == SCS_SEL_RST
                   && !auto_force_internal && internal_freq_select_r == SCS_FREQ_PLL;

  // PLL flag set or cleared on completed switch
  always_ff @(posedge clock) begin
    if (!rst_n) pll_ready_flag_r <= 1'b0;
    else if (!sw.busy && sw.cur == SCS_SRC_CFG && pll_req != pll_ready_flag_r && pll_osc_level == pll_req)
      pll_ready_flag_r <= pll_req;
  end

  // start status: external config source active, timer done in crystal modes
  assign start_timer_status = (sw.cur == SCS_SRC_CFG) && !auto_force_internal
                              && (start_up_timer_done || !crystal_mode);

  always_ff @(posedge clock) begin
    if (!rst_n) sys_clk_out <= 1'b0;
    else if (gate_low) sys_clk_out <= 1'b0;
    else if (pll_ready_flag_r && sw.cur == SCS_SRC_CFG) sys_clk_out <= pll_osc_level;
    else sys_clk_out <= src_lvl[sw.cur];
  end

  // Active source outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_source <= SCS_SRC_CFG;
      active_freq <= SCS_FREQ_RST;
      pll_active <= 1'b0;
    end else begin
      active_source <= sw.cur;
      active_freq <= freq_r;
      pll_active <= pll_ready_flag_r;
    end
  end

  // status read-only: no write path to status
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      SCS_OFF_CTRL: rdata_nxt = {software_pll_enable_r, internal_freq_select_r, 1'b0, clock_source_select_r};
      SCS_OFF_STAT: begin
        rdata_nxt[SCS_STS_BIT] = start_timer_status;
        rdata_nxt[SCS_SECONDARY_OSC_READY_BIT] = secondary_osc_ready;
        rdata_nxt[SCS_PLL_READY_FLAG_BIT] = pll_ready_flag_r;
        rdata_nxt[SCS_BUSY_BIT] = sw.busy;
      end
      SCS_OFF_TIMER1_CONTROL_REG: rdata_nxt[SCS_SECONDARY_OSC_ENABLE_BIT] = secondary_osc_enable_r;
      default: rdata_nxt = 8'h00;
    endcase
  end
  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rdata_nxt;
    else reg_rdata <= 8'h00;
  end

  // Checks
  // select clear after reset
  chk_sel_reset: assert property (@(posedge clock) !rst_n |=> clock_source_select_r == 2'h0)
    else $error("select not cleared");
  chk_freq_reset: assert property (@(posedge clock) !rst_n |=> internal_freq_select_r == 4'h7)
    else $error("frequency reset wrong");
  chk_auto_keep: assert property (@(posedge clock) disable iff (!rst_n)
    (auto_force_internal && !reg_wr) |=> $stable(clock_source_select_r)) else $error("select changed by override");
  chk_sec_run: assert property (@(posedge clock) disable iff (!rst_n)
    secondary_osc_run == secondary_osc_enable_r) else $error("secondary run mismatch");
  chk_sec_ready: assert property (@(posedge clock) disable iff (!rst_n)
    secondary_osc_ready |-> secondary_osc_enable_r) else $error("ready without enable");
  // PLL flag rises only after select 00
  chk_pll_sel: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pll_ready_flag_r) |-> $past(clock_source_select_r) == 2'h0) else $error("PLL with bad select");
  chk_stat_ro: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && reg_addr == SCS_OFF_STAT) |=> $stable(pll_ready_flag_r) || !$stable(pll_req))
    else $error("status written");
  chk_int_sel: assert property (@(posedge clock) disable iff (!rst_n)
    sw.done && clock_source_select_r[1] |-> sw.cur == SCS_SRC_INT) else $error("internal not active");
  chk_sts_sec: assert property (@(posedge clock) disable iff (!rst_n)
    sw.cur == SCS_SRC_SEC |-> !start_timer_status) else $error("start status on secondary");
  chk_out_low: assert property (@(posedge clock) disable iff (!rst_n)
    gate_low |=> !sys_clk_out) else $error("output not held low");
  // Read data one cycle only
  chk_rd_zero: assert property (@(posedge clock) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data stuck");
  cov_to_sec: cover property (@(posedge clock) disable iff (!rst_n) sw.done && sw.cur == SCS_SRC_SEC);
  cov_pll_on: cover property (@(posedge clock) disable iff (!rst_n) $rose(pll_ready_flag_r));
  cov_auto: cover property (@(posedge clock) disable iff (!rst_n) $rose(auto_force_internal));
endmodule : scs_top

/* scs_osc_model.sv */
// Behavioural model of the oscillators that feed the clock source switch.
// Assumes every level is sampled on the system clock that drives this model.
`timescale 1ns/1ps
module scs_osc_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic secondary_osc_run,
  output logic cfg_osc_level,
  output logic secondary_osc_level,
  output logic secondary_osc_stable,
  output logic internal_osc_level,
  output logic pll_osc_level
);
  logic [7:0] tick_r; // Free running cycle count
  logic [4:0] warm_r; // Secondary warm-up count
  // Primary sources run free at differing rates
  always_ff @(posedge clock) begin
    if (!rst_n) tick_r <= 8'h00;
    else tick_r <= tick_r + 8'h01;
  end
  assign cfg_osc_level = tick_r[1];
  assign internal_osc_level = tick_r[2];
  assign pll_osc_level = tick_r[0];
  always_ff @(posedge clock) begin
    if (!rst_n || !secondary_osc_run) warm_r <= 5'h00;
    else if (warm_r != 5'h1f) warm_r <= warm_r + 5'h01;
  end
  assign secondary_osc_level = secondary_osc_run & tick_r[3];
  // Usable only after the full warm-up
  assign secondary_osc_stable = (warm_r == 5'h1f);
endmodule : scs_osc_model

/* system_clock_source_switch_tb.sv */
// Self-checking bench for the clock source switch top.
// Assumes a 50 MHz clock and the oscillator model on the far side.
`timescale 1ns/1ps
module system_clock_source_switch_tb;
  import scs_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, auto_force_internal = 1'b0, rd_seen = 1'b0;
  logic [1:0] reg_addr = 2'h0, active_source;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_last;
  logic cfg_l, sec_l, sec_st, int_l, pll_l, secondary_osc_run, sys_clk_out, pll_active;
  logic sut_done = 1'b1; // Start-up timer expired
  logic lvl; // Internal level seen one cycle earlier
  logic [3:0] active_freq, fr;
  logic [7:0] exp_q[$], msk_q[$]; // Expected read data and masks
  int err_total = 0, checks = 0, seed = 32'h6829_84c7, i;
  scs_top scs_top_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_oscillator_select(3'b100),
    .crystal_mode(1'b1), .start_up_timer_done(sut_done), .cfg_osc_level(cfg_l), .secondary_osc_level(sec_l),
    .secondary_osc_stable(sec_st), .internal_osc_level(int_l), .pll_osc_level(pll_l),
    .auto_force_internal(auto_force_internal), .secondary_osc_run(secondary_osc_run),
    .sys_clk_out(sys_clk_out), .active_source(active_source), .active_freq(active_freq),
    .pll_active(pll_active));
  scs_osc_model scs_osc_model_i (.clock(clock), .rst_n(rst_n), .secondary_osc_run(secondary_osc_run),
    .cfg_osc_level(cfg_l), .secondary_osc_level(sec_l), .secondary_osc_stable(sec_st),
    .internal_osc_level(int_l), .pll_osc_level(pll_l));
  // Clock generator
  initial begin
    forever #10 clock = ~clock;
  end
  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Let the edge's updates land
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step
  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read; the expectation is queued for the monitor
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd
  // Poll a status bit with a bounded count
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 100; n++) begin
      rd(SCS_OFF_STAT, 8'h00, 8'h00);
      step();
      if (rd_last[b] === v) break;
    end
    chk({7'h00, rd_last[b]}, {7'h00, v});
  endtask : poll
  // Wait for the active source under a bound
  task automatic wait_src(input logic [1:0] s);
    for (i = 0; i < 100 && active_source !== s; i++) step();
    chk({6'h00, active_source}, {6'h00, s});
  endtask : wait_src
  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) begin
      rd_last = reg_rdata;
      chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end
  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b000}, 8'hff);
    chk({4'h0, active_freq}, {4'h0, SCS_FREQ_RST});
    wr(SCS_OFF_STAT, 8'hff);
    rd(SCS_OFF_STAT, 8'h00, 8'h0e);
    rd(2'h3, 8'h00, 8'hff);
    wr(SCS_OFF_TIMER1_CONTROL_REG, 8'h01 << SCS_SECONDARY_OSC_ENABLE_BIT);
    #1;
    chk({7'h00, secondary_osc_run}, 8'h01);
    poll(SCS_SECONDARY_OSC_READY_BIT, 1'b1);
    wr(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b001});
    wait_src(SCS_SRC_SEC);
    rd(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b001}, 8'hff);
    for (int k = 2; k < 4; k++) begin
      fr = 4'($random(seed));
      wr(SCS_OFF_CTRL, {1'b1, fr, 1'b0, k[1:0]});
      wait_src(SCS_SRC_INT);
      repeat (2) step();
      chk({4'h0, active_freq}, {4'h0, fr});
      lvl = int_l;
      step();
      chk({7'h00, sys_clk_out}, {7'h00, lvl});
      chk({7'h00, pll_active}, 8'h00);
      fr = fr ^ 4'h1;
      wr(SCS_OFF_CTRL, {1'b0, fr, 1'b0, k[1:0]});
      for (i = 0; i < 12 && active_freq !== fr; i++) step();
      chk({4'h0, active_freq}, {4'h0, fr});
      wr(SCS_OFF_CTRL, {1'b0, fr, 1'b0, k[1:0]});
      rd(SCS_OFF_STAT, 8'h00, 8'h08);
    end
    wr(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b000});
    poll(SCS_BUSY_BIT, 1'b0);
    wait_src(SCS_SRC_CFG);
    @(posedge clock);
    auto_force_internal <= 1'b1;
    wait_src(SCS_SRC_INT);
    rd(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b000}, 8'h03);
    rd(SCS_OFF_STAT, 8'h00, 8'h01);
    @(posedge clock);
    auto_force_internal <= 1'b0;
    wait_src(SCS_SRC_CFG);
    wr(SCS_OFF_CTRL, {1'b1, SCS_FREQ_PLL, 3'b000});
    for (i = 0; i < 100 && pll_active !== 1'b1; i++) step();
    chk({7'h00, pll_active}, 8'h01);
    rd(SCS_OFF_STAT, 8'h04, 8'h04);
    wr(SCS_OFF_CTRL, {1'b0, SCS_FREQ_PLL, 3'b000});
    for (i = 0; i < 100 && pll_active !== 1'b0; i++) step();
    chk({7'h00, pll_active}, 8'h00);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(SCS_OFF_CTRL, {1'b0, SCS_FREQ_RST, 3'b000}, 8'hff);
    rd(SCS_OFF_STAT, 8'h01, 8'h01);
    @(posedge clock);
    sut_done <= 1'b0;
    rd(SCS_OFF_STAT, 8'h00, 8'h01);
    step();
    chk({6'h00, active_source}, 8'h00);
    report_and_stop();
  end
endmodule : system_clock_source_switch_tb
